// ---- src/oms_decode.sv ----
// How it works
// - The operating mode is taken from the two operating-mode straps.
// - The clock multiplication mode is taken from the two clock-mode straps.
// - Flash programming and erasing are permitted only when the guard allows.
// - Mode 0 puts spaces zero and four outside, 8-bit narrow, 16-bit wide.
// - Mode 1 puts spaces zero and four outside, 16-bit narrow, 32-bit wide.
// - Mode 2 enables the internal ROM and still allows space zero externally.
// - Single-chip mode frees all port pins and never drives the address bus.
// - The system clock is the input clock times one, two or four.
// - With ROM on, 0x00000000 to 0x0003FFFF go to the 256-kbyte ROM.
// - With ROM off, spaces one to three are 4-Mbyte windows from 0x00400000.
// - The top 8 kbytes from 0xFFFFE000 always decode to internal RAM.
// - All eight modules stay in standby after reset until software releases them.
// - With guard high codes 00 to 11 give modes 0 to 3; low gives boot for 00, user for 10, invalid for 01 and 11.
// - Clock codes give system x1 x2 x4 x4 and peripheral x1 x2 x4 x2.
`timescale 1ns/10ps
`default_nettype none
module oms_decode #(
  parameter bit WIDE_VARIANT = 1'b0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic op_mode_sel_low,
  input wire logic op_mode_sel_high,
  input wire logic clk_mode_sel_low,
  input wire logic clk_mode_sel_high,
  input wire logic flash_write_guard_pin,
  input wire logic [31:0] addr,
  input wire logic [oms_pkg::OMS_STBY_W-1:0] standby_release,
  output oms_pkg::oms_config_t cfg,
  output oms_pkg::oms_region_t region,
  output logic [oms_pkg::OMS_STBY_W-1:0] module_standby
);

  logic [4:0] straps;
  logic [4:0] next_straps;
  oms_pkg::oms_config_t next_cfg;
  oms_pkg::oms_region_t next_region;
  logic [oms_pkg::OMS_STBY_W-1:0] next_module_standby;
  logic captured;
  logic next_captured;
  logic guard;
  logic [1:0] opm;
  logic [1:0] ckm;

  // Straps are only sampled on the first clock edge after reset release, so a glitch on the pins
  // during run time cannot move the address map under running code.
  always_comb
  begin
    next_straps = straps;
    next_captured = 1'b1;
    if (!captured)
      next_straps = {flash_write_guard_pin, clk_mode_sel_high,
                     clk_mode_sel_low, op_mode_sel_high, op_mode_sel_low};
  end

  // The reset value of straps is a constant; the real levels are caught by
  // the first clock edge after release, then frozen by the capture flag.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      straps <= 5'h10;
      captured <= 1'b0;
    end
    else
    begin
      straps <= next_straps;
      captured <= next_captured;
    end
  end

  assign guard = straps[4];
  assign opm = straps[1:0];
  assign ckm = straps[3:2];

  always_comb
  begin
    next_cfg = '0;
    next_cfg.mode = oms_pkg::OMS_INVALID;
    case ({guard, opm})
      3'h4: next_cfg.mode = oms_pkg::OMS_EXT0;
      3'h5: next_cfg.mode = oms_pkg::OMS_EXT1;
      3'h6: next_cfg.mode = oms_pkg::OMS_EXT2;
      3'h7: next_cfg.mode = oms_pkg::OMS_SINGLE;
      3'h0: next_cfg.mode = oms_pkg::OMS_BOOT;
      3'h2: next_cfg.mode = oms_pkg::OMS_USER_PROG;
      default: next_cfg.mode = oms_pkg::OMS_INVALID;
    endcase
    case (next_cfg.mode)
      oms_pkg::OMS_EXT0:
      begin
        next_cfg.ext_bus_enable = 1'b1;
        next_cfg.cs0_width = WIDE_VARIANT ? oms_pkg::OMS_BUS_16
                                          : oms_pkg::OMS_BUS_8;
      end
      oms_pkg::OMS_EXT1:
      begin
        next_cfg.ext_bus_enable = 1'b1;
        next_cfg.cs0_width = WIDE_VARIANT ? oms_pkg::OMS_BUS_32
                                          : oms_pkg::OMS_BUS_16;
      end
      oms_pkg::OMS_EXT2, oms_pkg::OMS_BOOT, oms_pkg::OMS_USER_PROG:
      begin
        // Width then belongs to the bus controller; 8 bits is its default.
        next_cfg.rom_enable = 1'b1;
        next_cfg.ext_bus_enable = 1'b1;
        next_cfg.cs0_width = oms_pkg::OMS_BUS_8;
      end
      oms_pkg::OMS_SINGLE:
      begin
        next_cfg.rom_enable = 1'b1;
        next_cfg.ext_bus_enable = 1'b0;
        next_cfg.cs0_width = oms_pkg::OMS_BUS_NONE;
      end
      default:
      begin
        next_cfg.ext_bus_enable = 1'b0;
      end
    endcase
    case (ckm)
      2'h0:
      begin
        next_cfg.sys_mul = oms_pkg::OMS_MUL_1;
        next_cfg.per_mul = oms_pkg::OMS_MUL_1;
      end
      2'h1:
      begin
        next_cfg.sys_mul = oms_pkg::OMS_MUL_2;
        next_cfg.per_mul = oms_pkg::OMS_MUL_2;
      end
      2'h2:
      begin
        next_cfg.sys_mul = oms_pkg::OMS_MUL_4;
        next_cfg.per_mul = oms_pkg::OMS_MUL_4;
      end
      default:
      begin
        next_cfg.sys_mul = oms_pkg::OMS_MUL_4;
        next_cfg.per_mul = oms_pkg::OMS_MUL_2;
      end
    endcase
    // Only the two programming modes with the guard low allow writes.
    next_cfg.flash_prog_allow = !guard &&
      (next_cfg.mode == oms_pkg::OMS_BOOT ||
       next_cfg.mode == oms_pkg::OMS_USER_PROG);
  end

  // Address decode works on the frozen configuration, one cycle of latency.
  always_comb
  begin
    next_region = '0;
    if (addr >= oms_pkg::OMS_RAM_BASE)
      next_region.ram = 1'b1;
    else if (addr >= oms_pkg::OMS_PERIPH_BASE &&
             addr <= oms_pkg::OMS_PERIPH_LAST)
      next_region.periph = 1'b1;
    else if (cfg.rom_enable && addr <= oms_pkg::OMS_ROM_LAST)
      next_region.rom = 1'b1;
    else if (!cfg.ext_bus_enable)
      next_region.reserved = 1'b1;
    else if (addr <= oms_pkg::OMS_CS_LAST)
    begin
      if (addr < oms_pkg::OMS_CS1_BASE)
      begin
        if (!cfg.rom_enable || addr >= oms_pkg::OMS_CS0_ON_ROM_BASE)
          next_region.cs[0] = 1'b1;
        else
          next_region.reserved = 1'b1;
      end
      else
        next_region.cs[addr[23:22]] = 1'b1;
    end
    else if (addr <= oms_pkg::OMS_CS4_LAST)
    begin
      if (!cfg.rom_enable || addr >= oms_pkg::OMS_CS4_ON_ROM_BASE)
        next_region.cs[4] = 1'b1;
      else
        next_region.reserved = 1'b1;
    end
    else if (addr <= oms_pkg::OMS_CS7_LAST)
      next_region.cs[3'(addr[24:22])] = 1'b1;
    else
      next_region.reserved = 1'b1;
  end

  // Standby bits set at reset and are cleared only by a software release.
  always_comb
  begin
    next_module_standby = module_standby & ~standby_release;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg <= '0;
      region <= '0;
      module_standby <= oms_pkg::OMS_STBY_RESET;
    end
    else
    begin
      cfg <= next_cfg;
      region <= next_region;
      module_standby <= next_module_standby;
    end
  end

endmodule
`default_nettype wire

// ---- include/oms_pkg.sv ----
package oms_pkg;

  // Operating mode after decode of the guard pin and the two mode straps.
  typedef enum logic [2:0] {
    OMS_EXT0 = 3'h0,
    OMS_EXT1 = 3'h1,
    OMS_EXT2 = 3'h3,
    OMS_SINGLE = 3'h2,
    OMS_BOOT = 3'h6,
    OMS_USER_PROG = 3'h7,
    OMS_INVALID = 3'h5
  } oms_mode_t;

  // External bus width codes.
  localparam logic [1:0] OMS_BUS_NONE = 2'h0;
  localparam logic [1:0] OMS_BUS_8 = 2'h1;
  localparam logic [1:0] OMS_BUS_16 = 2'h2;
  localparam logic [1:0] OMS_BUS_32 = 2'h3;

  // Clock ratio codes: value is log2 of the multiplier.
  localparam logic [1:0] OMS_MUL_1 = 2'h0;
  localparam logic [1:0] OMS_MUL_2 = 2'h1;
  localparam logic [1:0] OMS_MUL_4 = 2'h2;

  // Address map.
  localparam logic [31:0] OMS_ROM_BASE = 32'h00000000;
  localparam logic [31:0] OMS_ROM_LAST = 32'h0003FFFF;
  localparam logic [31:0] OMS_CS0_ON_ROM_BASE = 32'h00200000;
  localparam logic [31:0] OMS_CS1_BASE = 32'h00400000;
  localparam logic [31:0] OMS_CS2_BASE = 32'h00800000;
  localparam logic [31:0] OMS_CS3_BASE = 32'h00C00000;
  localparam logic [31:0] OMS_CS_LAST = 32'h00FFFFFF;
  localparam logic [31:0] OMS_CS4_BASE = 32'h01000000;
  localparam logic [31:0] OMS_CS4_ON_ROM_BASE = 32'h01200000;
  localparam logic [31:0] OMS_CS4_LAST = 32'h013FFFFF;
  localparam logic [31:0] OMS_CS5_BASE = 32'h01400000;
  localparam logic [31:0] OMS_CS7_LAST = 32'h01FFFFFF;
  localparam logic [31:0] OMS_PERIPH_BASE = 32'hFFFF8000;
  localparam logic [31:0] OMS_PERIPH_LAST = 32'hFFFFBFFF;
  localparam logic [31:0] OMS_RAM_BASE = 32'hFFFFE000;
  localparam logic [31:0] OMS_CS_SPAN_SHIFT = 32'h00000016;

  // Module standby mask after reset; bit set means held in standby.
  localparam int OMS_STBY_W = 8;
  localparam logic [7:0] OMS_STBY_RESET = 8'hFF;

  // Address decode result carried as one bundle.
  typedef struct packed {
    logic rom;
    logic ram;
    logic periph;
    logic [7:0] cs;
    logic reserved;
  } oms_region_t;

  // Decoded configuration carried as one bundle.
  typedef struct packed {
    oms_mode_t mode;
    logic rom_enable;
    logic ext_bus_enable;
    logic [1:0] cs0_width;
    logic [1:0] sys_mul;
    logic [1:0] per_mul;
    logic flash_prog_allow;
  } oms_config_t;

endpackage

// ---- test/oms_strap_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module oms_strap_model (
  input wire logic nrst,
  input wire logic [4:0] req,
  output logic [4:0] straps
);
  // Board straps only move while power-on reset is held low.
  always_latch
    if (!nrst)
      straps <= req;
endmodule
`default_nettype wire

// ---- test/oms_decode_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module oms_decode_chk #(
  parameter bit WIDE_VARIANT = 1'b0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic op_mode_sel_low,
  input wire logic op_mode_sel_high,
  input wire logic clk_mode_sel_low,
  input wire logic clk_mode_sel_high,
  input wire logic flash_write_guard_pin,
  input wire logic [31:0] addr,
  input wire logic [oms_pkg::OMS_STBY_W-1:0] standby_release,
  input wire oms_pkg::oms_config_t cfg,
  input wire oms_pkg::oms_region_t region,
  input wire logic [oms_pkg::OMS_STBY_W-1:0] module_standby
);
  localparam logic [1:0] W0 = WIDE_VARIANT ? 2'h2 : 2'h1;
  localparam logic [1:0] W1 = WIDE_VARIANT ? 2'h3 : 2'h2;
  oms_pkg::oms_mode_t mtab [8] = '{oms_pkg::OMS_BOOT, oms_pkg::OMS_INVALID,
    oms_pkg::OMS_USER_PROG, oms_pkg::OMS_INVALID, oms_pkg::OMS_EXT0,
    oms_pkg::OMS_EXT1, oms_pkg::OMS_EXT2, oms_pkg::OMS_SINGLE};
  logic [1:0] cnt;
  logic [4:0] cap;
  logic [1:0] win;
  logic [7:0] held;
  wire logic ready = cnt[1];
  // Straps are captured on the first edge after release, as the decode does.
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      cnt <= 2'h0;
      cap <= 5'h00;
      win <= 2'h0;
      held <= 8'h00;
    end
    else
    begin
      cnt <= cnt + {1'b0, ~&cnt};
      if (cnt == 2'h0)
        cap <= {flash_write_guard_pin, clk_mode_sel_high, clk_mode_sel_low,
          op_mode_sel_high, op_mode_sel_low};
      win <= addr[23:22];
      held <= module_standby & ~standby_release;
    end
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence s_ram_hit;
    ready && addr >= oms_pkg::OMS_RAM_BASE;
  endsequence
  a_mode_decode: assert property (ready |->
    cfg.mode == mtab[{cap[4], cap[1:0]}]) else $error("bad mode");
  a_clock_ratio: assert property (ready |->
    cfg.sys_mul == {cap[3], cap[2] & !cap[3]} && cfg.per_mul ==
    (&cap[3:2] ? 2'h1 : cap[3:2])) else $error("bad ratio");
  a_flash_guard: assert property (ready |->
    cfg.flash_prog_allow == (!cap[4] && !cap[0])) else $error("bad guard");
  a_bus_width: assert property (
    ready && !cfg.rom_enable && cap[4] |->
    cfg.ext_bus_enable && cfg.cs0_width == (cap[0] ? W1 : W0))
    else $error("bad width");
  a_cs_window: assert property (ready && cfg.ext_bus_enable &&
    !cfg.rom_enable && addr[31:24] == 8'h00 && addr[23:22] != 2'h0
    |=> region.cs[win]) else $error("bad cs window");
  a_ram_top: assert property (s_ram_hit |=> region.ram)
    else $error("bad ram");
  a_cfg_frozen: assert property (ready |=> $stable(cfg))
    else $error("cfg moved");
  a_standby_hold: assert property ((module_standby & held) == held)
    else $error("standby lost");
endmodule
bind oms_decode oms_decode_chk #(.WIDE_VARIANT(WIDE_VARIANT)) u_chk (
  .clock(clock), .nrst(nrst), .op_mode_sel_low(op_mode_sel_low),
  .op_mode_sel_high(op_mode_sel_high), .clk_mode_sel_low(clk_mode_sel_low),
  .clk_mode_sel_high(clk_mode_sel_high), .addr(addr),
  .flash_write_guard_pin(flash_write_guard_pin), .cfg(cfg),
  .standby_release(standby_release), .region(region),
  .module_standby(module_standby));
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] req = 5'h10;
  logic [4:0] pins;
  logic [31:0] addr = 32'h0;
  logic [7:0] rel = 8'h00;
  oms_pkg::oms_config_t cfg;
  oms_pkg::oms_region_t region;
  oms_pkg::oms_config_t cfg_w;
  logic [7:0] stby;
  logic rom;
  logic [11:0] low_hit;
  int n_mismatch = 0;
  int total_checks = 0;
  oms_pkg::oms_mode_t em [8] = '{oms_pkg::OMS_EXT0, oms_pkg::OMS_EXT1,
    oms_pkg::OMS_EXT2, oms_pkg::OMS_SINGLE, oms_pkg::OMS_BOOT,
    oms_pkg::OMS_INVALID, oms_pkg::OMS_USER_PROG, oms_pkg::OMS_INVALID};
  always #12.5 clock = ~clock;
  oms_strap_model M (.nrst(nrst), .req(req), .straps(pins));
  oms_decode DUT (.clock(clock), .nrst(nrst), .op_mode_sel_low(pins[0]),
    .op_mode_sel_high(pins[1]), .clk_mode_sel_low(pins[2]),
    .clk_mode_sel_high(pins[3]), .flash_write_guard_pin(pins[4]),
    .addr(addr), .standby_release(rel), .cfg(cfg), .region(region),
    .module_standby(stby));
  // The wide variant shares every input; only its bus widths are compared.
  oms_decode #(.WIDE_VARIANT(1'b1)) DUT_WIDE (.clock(clock), .nrst(nrst),
    .op_mode_sel_low(pins[0]), .op_mode_sel_high(pins[1]),
    .clk_mode_sel_low(pins[2]), .clk_mode_sel_high(pins[3]),
    .flash_write_guard_pin(pins[4]), .addr(addr), .standby_release(rel),
    .cfg(cfg_w), .region(), .module_standby());
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %0h vs %0h", $time, seen, want);
    end
  endtask
  task automatic look(input logic [31:0] a, input logic [11:0] want);
    addr = a;
    @(posedge clock);
    #1;
    check({20'h0, region}, {20'h0, want});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      nrst = 1'b0;
      req = {~i[2], i[0], i[1], i[1:0]};
      // Reset outlasts the settle time after each clock mode change.
      repeat (5) @(posedge clock);
      #1;
      nrst = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      rom = (i == 2 || i == 3 || i == 4 || i == 6);
      check(cfg.mode, em[i]);
      check(cfg.sys_mul, {i[0], i[1] & ~i[0]});
      check(cfg.per_mul, &i[1:0] ? 2'h1 : {i[0], i[1]});
      check(cfg.rom_enable, rom);
      check(cfg.flash_prog_allow, i == 4 || i == 6);
      if (i < 4)
        check(cfg.ext_bus_enable, i < 3);
      if (i < 2)
      begin
        check(cfg.cs0_width, i[0] ? 2'h2 : 2'h1);
        check(cfg_w.cs0_width, i[0] ? 2'h3 : 2'h2);
      end
      low_hit = rom ? 12'h800 : (i < 2) ? 12'h002 : 12'h001;
      look(oms_pkg::OMS_RAM_BASE, 12'h400);
      look(oms_pkg::OMS_RAM_BASE - 32'h1, 12'h001);
      look(oms_pkg::OMS_PERIPH_BASE, 12'h200);
      look(oms_pkg::OMS_ROM_LAST, low_hit);
      if (i < 3)
      begin
        look(oms_pkg::OMS_CS1_BASE, 12'h004);
        look(oms_pkg::OMS_CS2_BASE, 12'h008);
        look(oms_pkg::OMS_CS_LAST, 12'h010);
        look(oms_pkg::OMS_CS4_BASE, rom ? 12'h001 : 12'h020);
        look(oms_pkg::OMS_CS7_LAST, 12'h100);
      end
      if (i == 2)
      begin
        look(oms_pkg::OMS_ROM_LAST + 32'h1, 12'h001);
        look(oms_pkg::OMS_CS0_ON_ROM_BASE, 12'h002);
        look(oms_pkg::OMS_CS4_ON_ROM_BASE, 12'h020);
      end
      if (i == 3)
        look(oms_pkg::OMS_CS1_BASE, 12'h001);
      $display("test %0d done", i);
    end
    check(stby, 8'hFF);
    rel = 8'h01;
    @(posedge clock);
    #1;
    check(stby, 8'hFE);
    print_verdict();
  end
endmodule
`default_nettype wire
